// >>> sim/controller_model.sv
`timescale 1ns/100ps
module controller_model (
	input  wire        clk,
	output reg  [4:0]  status_len,
	output reg  [4:0]  filter_len,
	output reg         filter_word_mapped,
	output reg  [15:0] filter_word,
	output reg         filter_word_wr
);
initial begin
	status_len = 5'h00;
	filter_len = 5'h00;
	filter_word_mapped = 1'b0;
	filter_word = 16'h0000;
	filter_word_wr = 1'b0;
end
task wr(input [15:0] w);
	begin
		filter_word = w;
		filter_word_wr = 1'b1;
		@(posedge clk);
		#1 filter_word_wr = 1'b0;
		filter_word = ~w;
	end
endtask
endmodule // controller_model

// >>> sim/filter_properties.sv
`timescale 1ns/100ps
module filter_properties #(parameter POINTS = 32) (
	// clock and reset
	input wire logic              clk,
	input wire logic              arst_n,
	// inputs
	input wire logic [4:0]        status_len,
	input wire logic [4:0]        filter_len,
	input wire logic [POINTS-1:0] raw_in,
	input wire logic              tb_locked,
	input wire logic              module_ready,
	// outputs
	input wire logic [POINTS-1:0] in_data_reg,
	input wire logic [15:0]       status_word_reg,
	input wire logic              status_valid_reg,
	input wire logic              tb_added_reg,
	input wire logic              tb_lost_reg
);
default clocking @(posedge clk); endclocking
default disable iff (!arst_n);
chk_status_off_zero: assert property (
	status_len != 5'h10 |=> status_word_reg == 16'h0000) else $error("status not zero");
chk_valid_on_len: assert property (
	status_len == 5'h10 |=> status_valid_reg) else $error("status not valid");
chk_upper_bits_zero: assert property (
	status_word_reg[15:11] == 5'h00) else $error("upper status bits set");
chk_ready_inverted: assert property (
	status_len == 5'h10 |=> status_word_reg[9] == !$past(module_ready))
	else $error("ready bit sense");
chk_added_pulse: assert property (
	$rose(tb_locked) |=> tb_added_reg ##1 !tb_added_reg) else $error("added pulse");
chk_lost_pulse: assert property (
	$fell(tb_locked) |=> tb_lost_reg ##1 !tb_lost_reg) else $error("lost pulse");
chk_bypass_delay: assert property (
	filter_len == 5'h00 [*3] |-> in_data_reg == $past(raw_in, 2)) else $error("bypass");
chk_change_follows: assert property (
	$changed(in_data_reg[0]) |-> in_data_reg[0] == $past(raw_in[0], 2))
	else $error("spurious change");
endmodule // filter_properties
bind input_filter_and_status_word filter_properties #(.POINTS(POINTS)) chk (.clk, .arst_n,
	.status_len, .filter_len, .raw_in, .tb_locked, .module_ready, .in_data_reg,
	.status_word_reg, .status_valid_reg, .tb_added_reg, .tb_lost_reg);

// >>> sim/testbench.sv
`timescale 1ns/100ps
`define CHK(a,b) begin compares++; if ((a) !== (b)) begin errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
reg         clk, arst_n, tb_locked, module_ready;
reg  [31:0] raw_in;
wire [4:0]  status_len, filter_len;
wire        filter_word_mapped, filter_word_wr, status_valid_reg, tb_added_reg, tb_lost_reg;
wire [15:0] filter_word, status_word_reg;
wire [31:0] in_data_reg;
integer     errors = 0, compares = 0, cycles = 0;
controller_model ctl (.clk, .status_len, .filter_len, .filter_word_mapped, .filter_word,
	.filter_word_wr);
input_filter_and_status_word uut (.clk, .arst_n, .status_len, .filter_len,
	.filter_word_mapped, .filter_word, .filter_word_wr, .raw_in, .tb_locked, .module_ready,
	.in_data_reg, .status_word_reg, .status_valid_reg, .tb_added_reg, .tb_lost_reg);
initial begin clk = 0; forever #25 clk = ~clk; end
always @(posedge clk) if (++cycles > 70000) begin errors++; end_sim; end
task cyc(input integer n); begin repeat (n) @(posedge clk); #1; end endtask
task end_sim; begin
	$display("errors=%0d compares=%0d", errors, compares);
	if (errors == 0 && compares > 0) $display("All tests passed");
	else $display("Some tests failed");
	$finish;
end endtask
task status_test; begin
	`CHK(status_word_reg, 16'h0000)
	ctl.status_len = 5'h10; module_ready = 1'b0; cyc(2);
	`CHK(status_word_reg[15:9], 7'h01)
	`CHK(status_valid_reg, 1'b1)
	module_ready = 1'b1; tb_locked = 1'b0; cyc(1);
	`CHK(tb_lost_reg, 1'b1)
	`CHK(status_word_reg, 16'h0004)
	tb_locked = 1'b1; cyc(1);
	`CHK(status_word_reg[9], 1'b0)
	`CHK(tb_added_reg, 1'b1)
	`CHK(status_word_reg, 16'h0003)
end endtask
task reset_test; begin
	raw_in = 32'hffffffff; arst_n = 0; #1;
	`CHK(in_data_reg, 32'h00000000)
	cyc(2); arst_n = 1; cyc(9990);
	`CHK(in_data_reg, 32'h00000000)
	cyc(20);
	`CHK(in_data_reg, 32'hffffffff)
end endtask
task bypass_test; begin
	ctl.filter_len = 5'h10; raw_in = 32'ha5a5a5a5; cyc(2);
	`CHK(in_data_reg, 32'ha5a5a5a5)
	ctl.filter_len = 5'h00; ctl.filter_word_mapped = 1'b1; raw_in = 32'h5a5a5a5a; cyc(2);
	`CHK(in_data_reg, 32'h5a5a5a5a)
end endtask
task filter_test; begin
	ctl.filter_len = 5'h10; ctl.wr(16'hff01); cyc(1); ctl.wr(16'h0002);
	raw_in = 32'hffffffff; cyc(19900);
	`CHK(in_data_reg, 32'h5a5a5a5a)
	cyc(200);
	`CHK(in_data_reg, 32'hffffffff)
	ctl.wr(16'h0000); raw_in = 0; cyc(5000); raw_in = 32'hffffffff; cyc(6000);
	`CHK(in_data_reg, 32'hffffffff)
	raw_in = 0; cyc(9900);
	`CHK(in_data_reg, 32'hffffffff)
	cyc(200);
	`CHK(in_data_reg, 32'h00000000)
end endtask
initial begin
	arst_n = 0; tb_locked = 1; module_ready = 1; raw_in = 0;
	cyc(2); arst_n = 1; cyc(2);
	status_test; bypass_test; filter_test; reset_test;
	end_sim;
end
endmodule // testbench

// >>> verilog/input_filter_and_status_word.v
`timescale 1ns/100ps
// Behaviour
// - status length defaults to 0; status word only returned when length is 16
// - internal status occupies only the low eleven bits of the status word
// - status bit 9 is 1 when not ready, 0 when ready
// - filtering only when filter length is 16 and a filter word exists
// - filter length 0 means no filtering at all
// - one filter time applies to all points
// - new filter word takes effect at run time without reconfiguration
// - seven low-byte codes select 0.5, 1, 2, 5, 10, 50, 100 ms
// - upper byte of the filter word is ignored
// - turn-on and turn-off delays both equal the selected filter time
// - thirty-two input points, one data bit each
// - report terminal block added or lost from its lock state
`include "input_filter_consts.vh"
module input_filter_and_status_word #(
	parameter POINTS = 32,
	parameter CW     = 21
) (
	// clock and reset
	input  wire              clk,
	input  wire              arst_n,
	// configuration from controller
	input  wire [4:0]        status_len,
	input  wire [4:0]        filter_len,
	input  wire              filter_word_mapped,
	// filter time select word
	input  wire [15:0]       filter_word,
	input  wire              filter_word_wr,
	// field side
	input  wire [POINTS-1:0] raw_in,
	input  wire              tb_locked,
	input  wire              module_ready,
	// to controller
	output reg  [POINTS-1:0] in_data_reg,
	output reg  [15:0]       status_word_reg,
	output reg               status_valid_reg,
	output reg               tb_added_reg,
	output reg               tb_lost_reg
);
	// =====================================
	// cycle counts, 20 cycles per microsecond; 32-bit products cut to counter width
	localparam [31:0]   N_0P5 = `T_0P5MS_US * `CLK_MHZ - 1;
	localparam [31:0]   N_1   = `T_1MS_US * `CLK_MHZ - 1;
	localparam [31:0]   N_2   = `T_2MS_US * `CLK_MHZ - 1;
	localparam [31:0]   N_5   = `T_5MS_US * `CLK_MHZ - 1;
	localparam [31:0]   N_10  = `T_10MS_US * `CLK_MHZ - 1;
	localparam [31:0]   N_50  = `T_50MS_US * `CLK_MHZ - 1;
	localparam [31:0]   N_100 = `T_100MS_US * `CLK_MHZ - 1;
	localparam [CW-1:0] C_0P5 = N_0P5[CW-1:0];
	localparam [CW-1:0] C_1   = N_1[CW-1:0];
	localparam [CW-1:0] C_2   = N_2[CW-1:0];
	localparam [CW-1:0] C_5   = N_5[CW-1:0];
	localparam [CW-1:0] C_10  = N_10[CW-1:0];
	localparam [CW-1:0] C_50  = N_50[CW-1:0];
	localparam [CW-1:0] C_100 = N_100[CW-1:0];

	// =====================================
	// filter code decode
	function [CW:0] decode_sel;
		input [7:0] code;
		begin
			case (code)
				`SEL_0P5MS: decode_sel = {1'b1, C_0P5};
				`SEL_1MS:   decode_sel = {1'b1, C_1};
				`SEL_2MS:   decode_sel = {1'b1, C_2};
				`SEL_5MS:   decode_sel = {1'b1, C_5};
				`SEL_10MS:  decode_sel = {1'b1, C_10};
				`SEL_50MS:  decode_sel = {1'b1, C_50};
				`SEL_100MS: decode_sel = {1'b1, C_100};
				default:    decode_sel = {1'b0, {CW{1'b0}}};
			endcase
		end
	endfunction

	reg  [CW-1:0]     limit_reg;
	reg               tb_prev_reg;
	wire [CW:0]       dec;
	wire              filt_on;
	wire              stat_on;
	wire [POINTS-1:0] filt_out;

	assign dec     = decode_sel(filter_word[7:0]);
	assign filt_on = (filter_len == `LEN_WORD) && filter_word_mapped;
	assign stat_on = (status_len == `LEN_WORD);

	// =====================================
	// filter time register
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			limit_reg <= C_0P5;
		end else if (filter_word_wr && dec[CW]) begin
			limit_reg <= dec[CW-1:0];
		end
	end

	// =====================================
	// per-point filters, shared limit
	genvar i;
	generate
		for (i = 0; i < POINTS; i = i + 1) begin : g_pt
			point_debounce #(
				.CW(CW)
			) u_deb (
				.clk      (clk),
				.arst_n   (arst_n),
				.bypass   (!filt_on),
				.limit    (limit_reg),
				.raw      (raw_in[i]),
				.level_reg(filt_out[i])
			);
		end
	endgenerate

	// =====================================
	// input data and status
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			in_data_reg      <= {POINTS{1'b0}};
			status_word_reg  <= 16'h0000;
			status_valid_reg <= 1'b0;
			tb_added_reg     <= 1'b0;
			tb_lost_reg      <= 1'b0;
			tb_prev_reg      <= 1'b0;
		end else begin
			in_data_reg      <= filt_out;
			tb_prev_reg      <= tb_locked;
			tb_added_reg     <= tb_locked && !tb_prev_reg;
			tb_lost_reg      <= !tb_locked && tb_prev_reg;
			status_valid_reg <= stat_on;
			status_word_reg  <= 16'h0000;
			if (stat_on) begin
				status_word_reg[`ST_TB_PRESENT] <= tb_locked;
				status_word_reg[`ST_TB_ADDED]   <= tb_locked && !tb_prev_reg;
				status_word_reg[`ST_TB_LOST]    <= !tb_locked && tb_prev_reg;
				status_word_reg[`ST_READY_N]    <= !module_ready;
			end
		end
	end
endmodule // input_filter_and_status_word

// >>> verilog/input_filter_consts.vh
`ifndef INPUT_FILTER_CONSTS_VH
`define INPUT_FILTER_CONSTS_VH
// =====================================
// configured lengths
`define LEN_OFF        5'h00
`define LEN_WORD       5'h10
// =====================================
// filter select codes, low byte
`define SEL_0P5MS      8'h00
`define SEL_1MS        8'h01
`define SEL_2MS        8'h03
`define SEL_5MS        8'h09
`define SEL_10MS       8'h13
`define SEL_50MS       8'h63
`define SEL_100MS      8'hc7
// =====================================
// filter times in microseconds
`define T_0P5MS_US     500
`define T_1MS_US       1000
`define T_2MS_US       2000
`define T_5MS_US       5000
`define T_10MS_US      10000
`define T_50MS_US      50000
`define T_100MS_US     100000
`define CLK_MHZ        20
// =====================================
// status word bit positions
`define ST_READY_N     9
`define ST_TB_PRESENT  0
`define ST_TB_ADDED    1
`define ST_TB_LOST     2
`define ST_USED_BITS   11
`endif

// >>> verilog/point_debounce.v
`timescale 1ns/100ps
// =====================================
// one input point debounce counter
module point_debounce #(
	parameter CW = 21
) (
	// clock and reset
	input  wire          clk,
	input  wire          arst_n,
	// control
	input  wire          bypass,
	input  wire [CW-1:0] limit,
	// point
	input  wire          raw,
	output reg           level_reg
);
	reg [CW-1:0] cnt_reg;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg   <= {CW{1'b0}};
			level_reg <= 1'b0;
		end else if (bypass) begin
			cnt_reg   <= {CW{1'b0}};
			level_reg <= raw;
		end else if (raw == level_reg) begin
			cnt_reg <= {CW{1'b0}};
		end else if (cnt_reg >= limit) begin
			cnt_reg   <= {CW{1'b0}};
			level_reg <= raw;
		end else begin
			cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
		end
	end
endmodule // point_debounce
